/* design/aecs_defines.svh */
`ifndef AECS_DEFINES_SVH
`define AECS_DEFINES_SVH

////////////////////////////////////////////////////////////////////////
// host word indices, byte address is four times the index
`define AECS_IDX_DATA0     6'h00
`define AECS_IDX_DATA1     6'h01
`define AECS_IDX_DATA2     6'h02
`define AECS_IDX_DATA3     6'h03
`define AECS_IDX_CMD_STAT  6'h04
`define AECS_IDX_BYTE_CTL  6'h05

////////////////////////////////////////////////////////////////////////
// firmware port offsets (low nibble of the controller window)
`define AECS_EC_OUT_BASE   4'h0
`define AECS_EC_STATUS     4'h4
`define AECS_EC_BYTE_CTL   4'h5
`define AECS_EC_IN_BASE    4'h8

////////////////////////////////////////////////////////////////////////
// status register fields
`define AECS_ST_USER_HI    7
`define AECS_ST_MGMT_EVT   6
`define AECS_ST_OS_EVT     5
`define AECS_ST_BURST      4
`define AECS_ST_CMD        3
`define AECS_ST_USER_LO    2
`define AECS_ST_IN_FULL    1
`define AECS_ST_OUT_FULL   0

////////////////////////////////////////////////////////////////////////
// byte control field, reset values, flag byte positions
`define AECS_BCTL_FOUR     0
`define AECS_RST_BYTE      8'h00
`define AECS_RST_WORD      32'h0000_0000
`define AECS_FLAG_NARROW   2'h0
`define AECS_FLAG_WIDE     2'h3

`endif

/* design/aecs_pkg.sv */
package aecs_pkg;

  // one data or status byte
  typedef logic [7:0] aecs_byte_type;

  // whole state of the top module
  typedef struct packed {
    logic                ack;
    logic [31:0]         rdat;
    aecs_byte_type [3:0] obd;
    aecs_byte_type [3:0] ibd;
    logic                fourb;
    aecs_byte_type       ec_rdat;
  } aecs_top_state_type;

  // whole state of the status module
  typedef struct packed {
    aecs_byte_type stat;
  } aecs_stat_state_type;

endpackage : aecs_pkg

/* design/aecs_status.sv */
`timescale 1ns/1ps
`include "aecs_defines.svh"

module aecs_status (
  // system
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // firmware write
  input  wire logic       fw_we_i,
  input  wire logic [7:0] fw_dat_i,
  // hardware flag events
  input  wire logic       cmd_set_i,
  input  wire logic       cmd_clr_i,
  input  wire logic       ibf_set_i,
  input  wire logic       ibf_clr_i,
  input  wire logic       obf_set_i,
  input  wire logic       obf_clr_i,
  // status out
  output logic      [7:0] stat_o
);

  aecs_pkg::aecs_stat_state_type r_r;   // registered state
  aecs_pkg::aecs_stat_state_type r_nxt; // next state

  ////////////////////////////////////////////////////////////////////////
  // next state: firmware first, then clears, then sets
  always_comb begin
    r_nxt = r_r;
    // [RL6] firmware owns the byte
    // [RL7] user flag high only from firmware
    if (fw_we_i) begin
      r_nxt.stat = fw_dat_i;
    end
    // [RL12] hardware moves bits three, one and zero only
    // clears lose against sets below
    if (cmd_clr_i) begin
      r_nxt.stat[`AECS_ST_CMD] = 1'b0;
    end
    if (ibf_clr_i) begin
      r_nxt.stat[`AECS_ST_IN_FULL] = 1'b0;
    end
    if (obf_clr_i) begin
      r_nxt.stat[`AECS_ST_OUT_FULL] = 1'b0;
    end
    // [RL17] hardware sets win last
    if (cmd_set_i) begin
      r_nxt.stat[`AECS_ST_CMD] = 1'b1;
    end
    if (ibf_set_i) begin
      r_nxt.stat[`AECS_ST_IN_FULL] = 1'b1;
    end
    if (obf_set_i) begin
      r_nxt.stat[`AECS_ST_OUT_FULL] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r.stat <= `AECS_RST_BYTE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign stat_o = r_r.stat;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // [RL17] set beats firmware value
  chk_cmd_set_wins: assert property (cmd_set_i |=> stat_o[`AECS_ST_CMD] && stat_o[`AECS_ST_IN_FULL]) // [RL17]
    else $error("command flags lost against firmware write");
  // [RL12] burst bit only by firmware
  chk_burst_hold: assert property (!fw_we_i |=> stat_o[`AECS_ST_BURST] == $past(stat_o[`AECS_ST_BURST])) // [RL12]
    else $error("burst bit changed without firmware write");
  // [RL10] event flags stay software flags
  chk_evt_flags_sw: assert property (!fw_we_i |=> stat_o[7:5] == $past(stat_o[7:5])) // [RL10]
    else $error("event or user flags changed by hardware");
  // [RL6] firmware value lands
  chk_fw_write: assert property (fw_we_i |=> stat_o[7:4] == $past(fw_dat_i[7:4])) // [RL6]
    else $error("firmware status write not stored");

endmodule : aecs_status

/* design/aecs_top.sv */
//
// Contract
// [RL1] host data byte two, reset zero
// [RL2] host data byte three, reset zero
// [RL3] command write fills inbound byte zero
// [RL4] command write sets command and inbound-full
// [RL5] status view is host read-only
// [RL6] firmware reads and writes status byte
// [RL7] user flag high from firmware, reset zero
// [RL8] firmware sets mgmt flag before request
// [RL9] firmware keeps os event flag current
// [RL10] no interrupt outputs, flags are software
// [RL11] firmware shows burst mode in bit four
// [RL12] hardware never touches burst bit
// [RL13] any data write clears command flag; here only writes with lane zero on
// [RL14] writes go inbound, reads come outbound
// [RL15] narrow mode: bytes one-three dead
// [RL16] wide mode: byte three drives flags
// [RL17] hardware flag sets beat firmware write
`timescale 1ns/1ps
`include "aecs_defines.svh"

module aecs_top (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // host wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // firmware register port
  input  wire logic        ec_stb_i,
  input  wire logic        ec_we_i,
  input  wire logic [3:0]  ec_adr_i,
  input  wire logic [7:0]  ec_dat_i,
  output logic      [7:0]  ec_dat_o,
  // status byte for observation
  // [RL10] no interrupt output on purpose
  output logic      [7:0]  status_o
);

  ////////////////////////////////////////////////////////////////////////
  // block overview
  //
  // host side: one classic wishbone slave, word per register, byte in
  // the low lane. a request is taken on the edge where cyc and stb are
  // high and ack is low; ack follows one cycle later as a single pulse.
  // the ack gate on the take keeps a held request from firing twice,
  // which matters because a second command write would set the flags
  // again after firmware had already drained them.
  //
  // firmware side: a plain strobe port, no handshake, one access per
  // strobe cycle. read data is registered and stands until the next
  // firmware read, so firmware may sample it late.
  //
  // limitation: only the low lane carries data; a write with lane zero
  // off is acked and dropped, which keeps the flag logic simple at the
  // price of ignoring wide host stores.
  //
  // trade-off: both sides see one shared status byte held in the
  // status submodule, so the same-cycle priority between firmware
  // writes and hardware flag events lives in exactly one place.
  //
  // the four-byte mode bit is firmware owned; the host only reads it.
  // a mode change while a message is half moved is not guarded, the
  // firmware must switch modes only with both full flags clear.

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // byte is registered in the current access mode
  function automatic logic byte_live(input logic [1:0] b, input logic four);
    byte_live = four || (b == `AECS_FLAG_NARROW);
  endfunction : byte_live

  // byte whose access moves the full flags
  function automatic logic flag_byte(input logic [1:0] b, input logic four);
    flag_byte = four ? (b == `AECS_FLAG_WIDE) : (b == `AECS_FLAG_NARROW);
  endfunction : flag_byte

  ////////////////////////////////////////////////////////////////////////
  // state and wires
  aecs_pkg::aecs_top_state_type r_r;   // registered state
  aecs_pkg::aecs_top_state_type r_nxt; // next state
  logic [7:0] stat;       // status byte from submodule
  logic       host_req;   // new host request this cycle
  logic [5:0] hidx;       // host word index
  logic       hwr;        // host write taken
  logic       hrd;        // host read taken
  logic       hdata;      // index hits a data byte
  logic [3:0] hwe;        // per byte host store enable
  logic       ec_wr;      // firmware write
  logic       ec_rd;      // firmware read
  logic       cmd_set;    // command port written
  logic       cmd_clr;    // data byte written
  logic       ibf_set;    // inbound becomes full
  logic       ibf_clr;    // firmware drained inbound
  logic       obf_set;    // firmware filled outbound
  logic       obf_clr;    // host drained outbound
  logic       fw_we;      // firmware status write

  // one new request per bus cycle; ack blocks a second take
  assign host_req = wb_cyc_i && wb_stb_i && !r_r.ack;
  assign hidx     = wb_adr_i[7:2];
  // writes need the low lane, where the byte sits
  assign hwr      = host_req && wb_we_i && wb_sel_i[0];
  assign hrd      = host_req && !wb_we_i;
  assign hdata    = (hidx[5:2] == 4'h0);
  assign ec_wr    = ec_stb_i && ec_we_i;
  assign ec_rd    = ec_stb_i && !ec_we_i;

  ////////////////////////////////////////////////////////////////////////
  // per byte store enables
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      // [RL15] dead bytes never stored
      assign hwe[g] = hwr && (hidx == 6'(g)) && byte_live(2'(g), r_r.fourb);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // flag events toward the status byte
  always_comb begin
    // [RL4] command write sets both flags
    cmd_set = hwr && (hidx == `AECS_IDX_CMD_STAT);
    // [RL13] any data write with lane zero on, either mode
    cmd_clr = hwr && hdata;
    // [RL16] flag byte follows the mode
    ibf_set = cmd_set || (hwr && hdata && flag_byte(hidx[1:0], r_r.fourb));
    obf_clr = hrd && hdata && flag_byte(hidx[1:0], r_r.fourb);
    // firmware side mirrors the same byte choice
    obf_set = ec_wr && (ec_adr_i[3:2] == 2'h0) && flag_byte(ec_adr_i[1:0], r_r.fourb);
    ibf_clr = ec_rd && (ec_adr_i[3:2] == 2'h2) && flag_byte(ec_adr_i[1:0], r_r.fourb);
    // [RL6] firmware writes status
    fw_we   = ec_wr && (ec_adr_i == `AECS_EC_STATUS);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    r_nxt     = r_r;
    // ack pulses one cycle after the request is seen
    r_nxt.ack = host_req;
    // host stores into inbound bytes
    for (int i = 0; i < 4; i++) begin
      // [RL14] host data lands inbound
      if (hwe[i]) begin
        r_nxt.ibd[i] = wb_dat_i[7:0];
      end
    end
    // [RL3] command aliases inbound byte zero
    if (cmd_set) begin
      r_nxt.ibd[0] = wb_dat_i[7:0];
    end
    // host read data, upper bits always zero
    if (hrd) begin
      r_nxt.rdat = `AECS_RST_WORD;
      if (hdata) begin
        // [RL14] reads come from outbound
        if (byte_live(hidx[1:0], r_r.fourb)) begin
          r_nxt.rdat[7:0] = r_r.obd[hidx[1:0]];
        end
      end else if (hidx == `AECS_IDX_CMD_STAT) begin
        // [RL5] status view at command offset
        r_nxt.rdat[7:0] = stat;
      end else if (hidx == `AECS_IDX_BYTE_CTL) begin
        // host sees the mode but cannot change it
        r_nxt.rdat[`AECS_BCTL_FOUR] = r_r.fourb;
      end
    end
    // firmware writes
    if (ec_wr) begin
      if (ec_adr_i[3:2] == 2'h0) begin
        r_nxt.obd[ec_adr_i[1:0]] = ec_dat_i;
      end else if (ec_adr_i == `AECS_EC_BYTE_CTL) begin
        r_nxt.fourb = ec_dat_i[`AECS_BCTL_FOUR];
      end
    end
    // firmware reads, unmapped offsets give zero
    if (ec_rd) begin
      if (ec_adr_i[3:2] == 2'h2) begin
        r_nxt.ec_rdat = r_r.ibd[ec_adr_i[1:0]];
      end else if (ec_adr_i[3:2] == 2'h0) begin
        r_nxt.ec_rdat = r_r.obd[ec_adr_i[1:0]];
      end else if (ec_adr_i == `AECS_EC_STATUS) begin
        r_nxt.ec_rdat = stat;
      end else if (ec_adr_i == `AECS_EC_BYTE_CTL) begin
        r_nxt.ec_rdat = {7'h00, r_r.fourb};
      end else begin
        r_nxt.ec_rdat = `AECS_RST_BYTE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // [RL1] all bytes clear on reset
      // [RL2] byte three included
      r_r.ack     <= 1'b0;
      r_r.rdat    <= `AECS_RST_WORD;
      r_r.obd     <= {4{`AECS_RST_BYTE}};
      r_r.ibd     <= {4{`AECS_RST_BYTE}};
      r_r.fourb   <= 1'b0;
      r_r.ec_rdat <= `AECS_RST_BYTE;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status byte with flag priority
  aecs_status u_status (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fw_we_i   (fw_we),
    .fw_dat_i  (ec_dat_i),
    .cmd_set_i (cmd_set),
    .cmd_clr_i (cmd_clr),
    .ibf_set_i (ibf_set),
    .ibf_clr_i (ibf_clr),
    .obf_set_i (obf_set),
    .obf_clr_i (obf_clr),
    .stat_o    (stat)
  );

  // outputs straight from flip-flops
  assign wb_ack_o = r_r.ack;
  assign wb_dat_o = r_r.rdat;
  assign ec_dat_o = r_r.ec_rdat;
  assign status_o = stat;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // [RL1] byte two stored inbound
  chk_byte_two_store: assert property (hwe[2] |=> r_r.ibd[2] == $past(wb_dat_i[7:0])) // [RL1]
    else $error("host byte two not stored");
  // [RL2] byte three stored inbound
  chk_byte_three_store: assert property (hwe[3] |=> r_r.ibd[3] == $past(wb_dat_i[7:0])) // [RL2]
    else $error("host byte three not stored");
  // [RL3] command lands in byte zero
  chk_cmd_alias: assert property (cmd_set |=> r_r.ibd[0] == $past(wb_dat_i[7:0])) // [RL3]
    else $error("command byte not in inbound byte zero");
  // [RL4] command sets both flags
  chk_cmd_flags: assert property (cmd_set |=> stat[`AECS_ST_CMD] && stat[`AECS_ST_IN_FULL]) // [RL4]
    else $error("command write left a flag clear");
  // [RL5] status read answers with old status
  chk_stat_read: assert property (hrd && hidx == `AECS_IDX_CMD_STAT |=> wb_ack_o && wb_dat_o == {24'h0, $past(stat)}) // [RL5]
    else $error("status view read wrong");
  // [RL13] data write clears command flag
  chk_data_cmd_clr: assert property (hwr && hdata |=> !stat[`AECS_ST_CMD]) // [RL13]
    else $error("data write left command flag set");
  // [RL15] dead byte reads zero
  chk_dead_read: assert property (hrd && hdata && hidx[1:0] != 2'h0 && !r_r.fourb |=> wb_dat_o == 32'h0) // [RL15]
    else $error("dead byte read not zero");
  // [RL15] dead byte write keeps storage
  chk_dead_write: assert property (hwr && hidx == `AECS_IDX_DATA1 && !r_r.fourb |=> $stable(r_r.ibd[1])) // [RL15]
    else $error("dead byte write stored data");
  // [RL16] wide byte three fills inbound
  chk_wide_ibf: assert property (hwr && hidx == `AECS_IDX_DATA3 && r_r.fourb |=> stat[`AECS_ST_IN_FULL]) // [RL16]
    else $error("wide write did not set inbound full");
  // [RL16] wide byte three drains outbound
  chk_wide_obf: assert property (hrd && hidx == `AECS_IDX_DATA3 && r_r.fourb && !obf_set |=> !stat[`AECS_ST_OUT_FULL]) // [RL16]
    else $error("wide read did not clear outbound full");
  // [RL14] outbound data reaches host
  chk_out_read: assert property (hrd && hidx == `AECS_IDX_DATA0 |=> wb_dat_o[7:0] == $past(r_r.obd[0])) // [RL14]
    else $error("byte zero read wrong");
  // single cycle ack, then low
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // every take is answered next cycle
  chk_ack_take: assert property (host_req |=> wb_ack_o)
    else $error("host request not acked");
  // [RL1] byte two read from outbound
  chk_two_read: assert property (hrd && hidx == `AECS_IDX_DATA2 && r_r.fourb |=> wb_dat_o[7:0] == $past(r_r.obd[2])) // [RL1]
    else $error("byte two read wrong");
  // [RL2] byte three read from outbound
  chk_three_read: assert property (hrd && hidx == `AECS_IDX_DATA3 && r_r.fourb |=> wb_dat_o[7:0] == $past(r_r.obd[3])) // [RL2]
    else $error("byte three read wrong");
  // [RL14] upper lanes always zero
  chk_hi_lanes: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) // [RL14]
    else $error("upper read lanes not zero");
  // [RL3] command leaves inbound bytes one and three
  chk_cmd_only_zero: assert property (cmd_set |=> $stable(r_r.ibd[1]) && $stable(r_r.ibd[3])) // [RL3]
    else $error("command write touched other bytes");
  // [RL7] user flag from firmware write
  chk_user_hi: assert property (fw_we |=> stat[`AECS_ST_USER_HI] == $past(ec_dat_i[7])) // [RL7]
    else $error("user flag high not from firmware");
  // [RL15] dead write leaves inbound full
  chk_dead_ibf: assert property (hwr && hdata && hidx[1:0] != 2'h0 && !r_r.fourb && !fw_we && !ibf_clr
                                 |=> stat[`AECS_ST_IN_FULL] == $past(stat[`AECS_ST_IN_FULL])) // [RL15]
    else $error("dead byte write moved inbound full");
  // [RL15] dead read leaves outbound full
  chk_dead_obf: assert property (hrd && hdata && hidx[1:0] != 2'h0 && !r_r.fourb && !fw_we && !obf_set
                                 |=> stat[`AECS_ST_OUT_FULL] == $past(stat[`AECS_ST_OUT_FULL])) // [RL15]
    else $error("dead byte read moved outbound full");
  // [RL16] wide byte zero write keeps inbound clear
  chk_wide_zero: assert property (hwr && hidx == `AECS_IDX_DATA0 && r_r.fourb && !fw_we && !stat[`AECS_ST_IN_FULL]
                                  |=> !stat[`AECS_ST_IN_FULL]) // [RL16]
    else $error("wide byte zero write set inbound full");
  // [RL5] host cannot change the mode
  chk_ctl_ro: assert property (hwr && hidx == `AECS_IDX_BYTE_CTL && !ec_wr |=> $stable(r_r.fourb)) // [RL5]
    else $error("host write changed byte control");

  cov_cmd_write:  cover property (cmd_set ##1 ibf_clr);
  cov_wide_pair:  cover property (r_r.fourb && hwe[0] ##[1:8] hwe[3]);
  cov_stat_read:  cover property (hrd && hidx == `AECS_IDX_CMD_STAT && stat[`AECS_ST_IN_FULL]);
  cov_set_vs_fw:  cover property (cmd_set && fw_we);

endmodule : aecs_top

/* dv/acpi_ec_host_data_command_status_tb_top.sv */
`timescale 1ns/1ps

module acpi_ec_host_data_command_status_tb_top;

  logic        clk_i;        // system clock
  logic        rst_i;        // sync reset
  logic        cyc;          // host bus
  logic        stb;
  logic        we;
  logic        ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ec_stb;       // firmware port
  logic        ec_we;
  logic [3:0]  ec_adr;
  logic [7:0]  ec_wdat;
  logic [7:0]  ec_rdat;
  logic [7:0]  status;       // observed status byte
  int          mismatches;
  int          checks;

  aecs_host_model hm (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
                      .dat_o(wdat), .ack_i(ack), .dat_i(rdat));

  aecs_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
                .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .ec_stb_i(ec_stb),
                .ec_we_i(ec_we), .ec_adr_i(ec_adr), .ec_dat_i(ec_wdat), .ec_dat_o(ec_rdat), .status_o(status));

  ////////////////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // host write, low lane only
  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    hm.xfer(1'b1, a, {24'h000000, d}, q);
  endtask : hw

  // host read, upper lanes must read zero
  task automatic hr(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    hm.xfer(1'b0, a, 32'h0000_0000, q);
    chk("host read", {24'h000000, e}, q);
  endtask : hr

  // firmware access; one strobe cycle, then one cycle for the answer
  task automatic fw(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    ec_stb  <= 1'b1;
    ec_we   <= w;
    ec_adr  <= a;
    ec_wdat <= d;
    @(posedge clk_i);
    ec_stb  <= 1'b0;
    ec_wdat <= ~d;
    @(posedge clk_i);
    q = ec_rdat;
  endtask : fw

  task automatic fwr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    fw(1'b1, a, d, q);
  endtask : fwr

  task automatic fr(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    fw(1'b0, a, 8'h00, q);
    chk("firmware read", {24'h000000, e}, {24'h000000, q});
  endtask : fr

  task automatic st(input logic [7:0] e);
    chk("status", {24'h000000, e}, {24'h000000, status});
  endtask : st

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    st(8'h00);
    hr(8'h08, 8'h00);
    hr(8'h0c, 8'h00);
    hr(8'h10, 8'h00);
    fr(4'h2, 8'h00);
    fr(4'h5, 8'h00);
  endtask : t_reset

  task automatic t_command();
    hw(8'h10, 8'h5a);
    st(8'h0a);
    fr(4'h8, 8'h5a);
    hr(8'h10, 8'h08);
    hw(8'h00, 8'h11);
    st(8'h02);
    fr(4'h8, 8'h11);
    st(8'h00);
  endtask : t_command

  task automatic t_fw_status();
    // firmware keeps its flags: user, mgmt, os event, burst, user low
    fwr(4'h4, 8'hf4);
    st(8'hf4);
    hr(8'h10, 8'hf4);
    fr(4'h4, 8'hf4);
    hw(8'h10, 8'h01);
    st(8'hfe);
    fr(4'h8, 8'h01);
    hw(8'h00, 8'h02);
    st(8'hf6);
    fr(4'h8, 8'h02);
    // no events pending any more
    fwr(4'h4, 8'h00);
    hr(8'h10, 8'h00);
  endtask : t_fw_status

  task automatic t_narrow();
    fwr(4'h2, 8'h22);
    fwr(4'h3, 8'h33);
    hr(8'h08, 8'h00);
    hr(8'h0c, 8'h00);
    hw(8'h0c, 8'h99);
    st(8'h00);
    fr(4'hb, 8'h00);
  endtask : t_narrow

  task automatic t_wide();
    fwr(4'h5, 8'h01);
    fwr(4'h3, 8'h33);
    st(8'h01);
    hr(8'h08, 8'h22);
    st(8'h01);
    hr(8'h0c, 8'h33);
    st(8'h00);
    hw(8'h10, 8'h77);
    // byte zero is not the flag byte in wide mode, inbound stays full
    fr(4'h8, 8'h77);
    st(8'h0a);
    hw(8'h08, 8'hc2);
    st(8'h02);
    hw(8'h0c, 8'hc3);
    st(8'h02);
    fr(4'ha, 8'hc2);
    fr(4'hb, 8'hc3);
    st(8'h00);
  endtask : t_wide

  task automatic t_collide();
    // command and firmware status write taken at the same edge
    fork
      hw(8'h10, 8'h44);
      fwr(4'h4, 8'h80);
    join
    st(8'h8a);
    fr(4'h8, 8'h44);
    fwr(4'h4, 8'h00);
    hr(8'h40, 8'h00);
    hw(8'h40, 8'h55);
    st(8'h00);
  endtask : t_collide

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // hang guard, far above the roughly 150 cycles needed
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize();
  end

  // main sequence
  initial begin
    rst_i      = 1'b1;
    ec_stb     = 1'b0;
    ec_we      = 1'b0;
    ec_adr     = 4'h0;
    ec_wdat    = 8'h00;
    mismatches = 0;
    checks     = 0;
    t_reset();
    t_command();
    t_fw_status();
    t_narrow();
    t_wide();
    t_collide();
    t_reset();
    summarize();
  end

endmodule : acpi_ec_host_data_command_status_tb_top

/* dv/aecs_host_model.sv */
`timescale 1ns/1ps

// host driver issuing classic single wishbone cycles
module aecs_host_model (
  // system
  input  wire logic        clk_i,
  // wishbone master side
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i
);

  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h1;
    dat_o = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // one cycle; request held until ack is sampled, no latency assumed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines show junk, so stale values never pass for valid
    we_o  <= ~w;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask : xfer

endmodule : aecs_host_model
